// ==== verilog/sarseq_top.sv ====
// Converter control sequencer: APB registers, start/abort, sleep and SAR stepping
// Functional notes
// [R1] Done flag sets at every conversion end, irq enable or not.
// [R2] Only software clears the done flag, by writing zero.
// [R3] Interrupt request raised from done flag when irq enable set.
// [R4] A pending converter interrupt in sleep raises the wake request.
// [R5] Converter runs in sleep only with the RC conversion clock.
// [R6] Enable bit powers the converter; zero means powered off.
// [R7] Writing one to start bit begins conversion; bit reads busy.
// [R8] Software should not start in the same write that enables.
// [R9] Completion clears start bit, sets done flag, loads result.
// [R10] Early start-bit clear stores partial result, fill with last bit.
// [R11] Reset restores registers, powers off, aborts conversion.
// [R12] RC clock adds one instruction cycle delay before converting.
// [R13] Sleep completion with irq off powers down, enable bit stays.
// [R14] Sleep without RC clock aborts and powers down, enable stays.
// [R15] Special event sets start bit and clears the sixteen-bit timer.
// [R16] Channel field selects inputs 0-13, reserved, fixed reference.
// [R17] Clock field selects system clock dividers or RC clock.
// [R18] Reference field selects supply, external pin or fixed reference.
// [R19] Result register holds the eight-bit result.
// [R20] Unimplemented control bits read as zero.
// [R21] A conversion takes ten bit-resolve periods.
// [R22] Sample control and one comparator decision per period, MSB first.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module sarseq_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// APB slave
	input wire logic [sarseq_pkg::APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// System
	input wire logic sleep_active,
	input wire logic special_event,
	input wire logic rc_osc_clk,
	output logic irq_req,
	output logic wake_req,
	output logic timer_clear,
	// Analog core
	input wire logic cmp_result,
	output logic analog_power,
	output logic sample_en,
	output logic [7:0] dac_code,
	output logic [3:0] input_channel_select,
	output logic fixed_reference_channel,
	output logic [1:0] positive_ref_select
);
	import sarseq_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	sarseq_state_t state_reg, state_next;
	logic [7:0] ctrl0_reg, ctrl0_next;
	logic [7:0] ctrl1_reg, ctrl1_next;
	logic [7:0] result_reg, result_next;
	logic done_flag_reg, done_flag_next;
	logic irq_en_reg, irq_en_next;
	logic [7:0] work_reg, work_next;
	logic [3:0] per_reg, per_next;
	logic [2:0] dly_reg, dly_next;
	logic off_latch_reg, off_latch_next;
	logic rc_prev_reg;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic irq_reg, irq_next;
	logic wake_reg, wake_next;
	logic tclr_reg, tclr_next;
	logic apower_reg, apower_next;
	logic sample_reg, sample_next;
	logic [7:0] dac_reg, dac_next;
	logic fref_reg, fref_next;
	logic rc_sync;
	logic use_rc;
	logic setup;
	logic wr;
	logic mapped;
	logic [7:0] rdval;
	logic start_req;
	logic sw_abort;
	logic sleep_kill;
	logic complete;
	logic [2:0] bit_idx;

	sarseq_tick_if tk ();

	////////////////////////////////////////////////////////////////////////////
	// Submodules
	sarseq_sync #(
		.W(1)
	) u_rc_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.async_in(rc_osc_clk),
		.sync_out(rc_sync)
	);

	sarseq_tickgen u_tickgen (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.tk(tk)
	);

	// Clock select: x11 is RC, others are 2^n dividers
	assign use_rc = (ctrl1_reg[CTRL1_CS_LSB +: 2] == 2'b11); // R17
	assign tk.use_rc = use_rc;
	assign tk.rc_edge = rc_sync && !rc_prev_reg;
	assign tk.div_exp = 3'({1'b0, ctrl1_reg[CTRL1_CS_LSB +: 2]} * 3'd2 + {2'b00, ctrl1_reg[CTRL1_CS_LSB + 2]} + 3'd1); // R17
	assign tk.run = (state_reg == ST_CONV);

	////////////////////////////////////////////////////////////////////////////
	// Partial result fill: unresolved bits copy the last resolved bit
	function automatic logic [7:0] sarseq_fill(input logic [7:0] w, input logic [3:0] n);
		logic [7:0] f;
		logic [3:0] lb;
		f = w;
		lb = 4'(LAST_DECIDE_PERIOD - n);
		if (n == 4'h0) begin
			f = 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (4'(i) < lb) begin
					f[i] = w[lb[2:0]]; // R10
				end
			end
		end
		return f;
	endfunction : sarseq_fill

	////////////////////////////////////////////////////////////////////////////
	// Register read mux
	always_comb begin
		rdval = 8'h00;
		mapped = 1'b1;
		if (paddr == OFS_CTRL_ZERO) begin
			rdval = ctrl0_reg & CTRL_ZERO_MASK; // R20
		end else if (paddr == OFS_CTRL_ONE) begin
			rdval = ctrl1_reg & CTRL_ONE_MASK; // R20
		end else if (paddr == OFS_RESULT) begin
			rdval = result_reg; // R19
		end else if (paddr == OFS_PERIPH_FLAG) begin
			rdval[DONE_FLAG_BIT] = done_flag_reg;
		end else if (paddr == OFS_PERIPH_IRQEN) begin
			rdval[IRQ_EN_BIT] = irq_en_reg;
		end else begin
			mapped = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		state_next = state_reg;
		ctrl0_next = ctrl0_reg;
		ctrl1_next = ctrl1_reg;
		result_next = result_reg;
		done_flag_next = done_flag_reg;
		irq_en_next = irq_en_reg;
		work_next = work_reg;
		per_next = per_reg;
		dly_next = dly_reg;
		off_latch_next = off_latch_reg;
		prdata_next = prdata_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		start_req = 1'b0;
		sw_abort = 1'b0;
		complete = 1'b0;
		bit_idx = 3'(LAST_DECIDE_PERIOD - per_reg);

		// Bus phases: answer one cycle after setup
		setup = psel && !penable && !pready_reg;
		wr = psel && penable && pready_reg && pwrite;
		if (setup) begin
			pready_next = 1'b1;
			pslverr_next = !mapped;
			prdata_next = {24'h000000, rdval};
		end

		// Software writes
		if (wr) begin
			if (paddr == OFS_CTRL_ZERO) begin
				ctrl0_next[CTRL0_EN_BIT] = pwdata[CTRL0_EN_BIT]; // R6
				ctrl0_next[CTRL0_CHAN_LSB +: 4] = pwdata[CTRL0_CHAN_LSB +: 4]; // R16
				start_req = pwdata[CTRL0_GO_BIT] && !ctrl0_reg[CTRL0_GO_BIT]; // R7
				sw_abort = !pwdata[CTRL0_GO_BIT] && ctrl0_reg[CTRL0_GO_BIT]; // R10
			end else if (paddr == OFS_CTRL_ONE) begin
				ctrl1_next = pwdata[7:0] & CTRL_ONE_MASK; // R17 R18 R20
			end else if (paddr == OFS_RESULT) begin
				result_next = pwdata[7:0];
			end else if (paddr == OFS_PERIPH_FLAG) begin
				if (!pwdata[DONE_FLAG_BIT]) begin
					done_flag_next = 1'b0; // R2
				end
			end else if (paddr == OFS_PERIPH_IRQEN) begin
				irq_en_next = pwdata[IRQ_EN_BIT];
			end
		end

		// Hardware start from the capture/compare unit
		if (special_event && !ctrl0_reg[CTRL0_GO_BIT]) begin
			start_req = 1'b1; // R15
		end

		// Sleep with a system-derived clock kills the converter
		sleep_kill = sleep_active && !use_rc; // R5 R14

		// Power-down latch only lifts when sleep ends
		if (!sleep_active) begin
			off_latch_next = 1'b0;
		end

		// Sequencer
		case (state_reg)
			ST_IDLE: begin
				if (start_req && ctrl0_next[CTRL0_EN_BIT] && !sleep_kill) begin
					ctrl0_next[CTRL0_GO_BIT] = 1'b1; // R7 R15
					work_next = 8'h00;
					per_next = 4'h0;
					dly_next = 3'h0;
					state_next = use_rc ? ST_DELAY : ST_CONV; // R12
				end
			end
			ST_DELAY: begin
				dly_next = 3'(dly_reg + 3'd1);
				if (dly_reg == 3'(INSTR_CLKS - 3'd1)) begin
					state_next = ST_CONV; // R12
				end
			end
			ST_CONV: begin
				if (tk.tick) begin
					if (per_reg >= 4'h1 && per_reg <= LAST_DECIDE_PERIOD) begin
						work_next[bit_idx] = cmp_result; // R22
					end
					per_next = 4'(per_reg + 4'h1);
					if (per_reg == 4'(PERIODS_PER_CONV - 4'h1)) begin
						complete = 1'b1; // R21
					end
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase

		// Abort, disable and completion
		if (state_reg != ST_IDLE) begin
			if (!ctrl0_next[CTRL0_EN_BIT] || sleep_kill) begin
				state_next = ST_IDLE; // R6 R14
				ctrl0_next[CTRL0_GO_BIT] = 1'b0;
				if (sleep_kill) begin
					off_latch_next = 1'b1; // R14
				end
			end else if (sw_abort) begin
				state_next = ST_IDLE;
				ctrl0_next[CTRL0_GO_BIT] = 1'b0;
				if (state_reg == ST_CONV && per_reg > 4'h1) begin
					result_next = sarseq_fill(work_reg, 4'(per_reg - 4'h1)); // R10
				end else begin
					result_next = 8'h00; // R10
				end
			end else if (complete) begin
				state_next = ST_IDLE;
				ctrl0_next[CTRL0_GO_BIT] = 1'b0; // R9
				result_next = work_next; // R9
				if (sleep_active && !irq_en_reg) begin
					off_latch_next = 1'b1; // R13
				end
			end
		end else if (sleep_kill && ctrl0_reg[CTRL0_EN_BIT]) begin
			off_latch_next = 1'b1; // R14
		end

		// Set wins over a same-cycle software clear
		if (complete && !sw_abort && ctrl0_next[CTRL0_EN_BIT] && !sleep_kill) begin
			done_flag_next = 1'b1; // R1 R9
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output next values
	always_comb begin
		irq_next = done_flag_next && irq_en_next; // R3
		wake_next = sleep_active && done_flag_next && irq_en_next; // R4
		tclr_next = special_event; // R15
		fref_next = (ctrl0_next[CTRL0_CHAN_LSB +: 4] == CHAN_FIXED_REF); // R16
		apower_next = ctrl0_next[CTRL0_EN_BIT] && !off_latch_next && !(sleep_active && !use_rc); // R5 R6 R13
		sample_next = apower_next && !(state_next == ST_CONV && per_next != 4'h0); // R22
		dac_next = work_next;
		if (state_next == ST_CONV && per_next >= 4'h1 && per_next <= LAST_DECIDE_PERIOD) begin
			dac_next[3'(LAST_DECIDE_PERIOD - per_next)] = 1'b1; // R22
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_IDLE; // R11
			ctrl0_reg <= CTRL_ZERO_RST; // R11
			ctrl1_reg <= CTRL_ONE_RST;
			result_reg <= RESULT_RST;
			done_flag_reg <= 1'b0;
			irq_en_reg <= 1'b0;
			work_reg <= 8'h00;
			per_reg <= 4'h0;
			fref_reg <= 1'b0;
			dly_reg <= 3'h0;
			off_latch_reg <= 1'b0;
			rc_prev_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
			tclr_reg <= 1'b0;
			apower_reg <= 1'b0;
			sample_reg <= 1'b0;
			dac_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			ctrl0_reg <= ctrl0_next;
			ctrl1_reg <= ctrl1_next;
			result_reg <= result_next;
			done_flag_reg <= done_flag_next;
			irq_en_reg <= irq_en_next;
			work_reg <= work_next;
			per_reg <= per_next;
			fref_reg <= fref_next;
			dly_reg <= dly_next;
			off_latch_reg <= off_latch_next;
			rc_prev_reg <= rc_sync;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			irq_reg <= irq_next;
			wake_reg <= wake_next;
			tclr_reg <= tclr_next;
			apower_reg <= apower_next;
			sample_reg <= sample_next;
			dac_reg <= dac_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Port drive
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq_req = irq_reg;
	assign wake_req = wake_reg;
	assign timer_clear = tclr_reg;
	assign analog_power = apower_reg;
	assign sample_en = sample_reg;
	assign dac_code = dac_reg;
	assign input_channel_select = ctrl0_reg[CTRL0_CHAN_LSB +: 4]; // R16
	assign fixed_reference_channel = fref_reg; // R16
	assign positive_ref_select = ctrl1_reg[CTRL1_REF_LSB +: 2]; // R18
endmodule : sarseq_top

// ==== verilog/sarseq_pkg.sv ====
// Constants and types shared by the converter sequencer files
package sarseq_pkg;

	// Bus and register layout
	localparam int APB_AW = 12;
	localparam logic [11:0] OFS_CTRL_ZERO = 12'h000;
	localparam logic [11:0] OFS_CTRL_ONE = 12'h004;
	localparam logic [11:0] OFS_RESULT = 12'h008;
	localparam logic [11:0] OFS_PERIPH_FLAG = 12'h00C;
	localparam logic [11:0] OFS_PERIPH_IRQEN = 12'h010;

	// Field positions
	localparam int CTRL0_EN_BIT = 0;
	localparam int CTRL0_GO_BIT = 1;
	localparam int CTRL0_CHAN_LSB = 2;
	localparam int CTRL1_REF_LSB = 0;
	localparam int CTRL1_CS_LSB = 4;
	localparam int DONE_FLAG_BIT = 6;
	localparam int IRQ_EN_BIT = 6;

	// Reset values and implemented-bit masks
	localparam logic [7:0] CTRL_ZERO_RST = 8'h00;
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] RESULT_RST = 8'h00;
	localparam logic [7:0] CTRL_ZERO_MASK = 8'h3F;
	localparam logic [7:0] CTRL_ONE_MASK = 8'h73;

	// Channel codes
	localparam logic [3:0] CHAN_RESERVED = 4'hE;
	localparam logic [3:0] CHAN_FIXED_REF = 4'hF;

	// Timing counts
	localparam logic [3:0] PERIODS_PER_CONV = 4'hA;
	localparam logic [3:0] LAST_DECIDE_PERIOD = 4'h8;
	localparam int CLK_PERIOD_NS = 10;
	localparam int INSTR_NS = 40;
	localparam logic [2:0] INSTR_CLKS = 3'(INSTR_NS / CLK_PERIOD_NS);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DELAY,
		ST_CONV
	} sarseq_state_t;

endpackage : sarseq_pkg

// ==== verilog/sarseq_tick_if.sv ====
// Bit-period tick request and answer between sequencer and divider
`timescale 1ns/1ps
interface sarseq_tick_if;
	logic run;
	logic use_rc;
	logic rc_edge;
	logic [2:0] div_exp;
	logic tick;

	modport gen (input run, input use_rc, input rc_edge, input div_exp, output tick);
	modport user (output run, output use_rc, output rc_edge, output div_exp, input tick);
endinterface : sarseq_tick_if

// ==== verilog/sarseq_sync.sv ====
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module sarseq_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	import sarseq_pkg::*;

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] out_reg;
	logic [W-1:0] out_next;

	always_comb begin
		out_next = out_reg;
		if (s2_reg == s3_reg) begin
			out_next = s3_reg;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			out_reg <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign sync_out = out_reg;
endmodule : sarseq_sync

// ==== verilog/sarseq_tickgen.sv ====
// Bit-period tick from system clock divider or RC oscillator edge
`timescale 1ns/1ps
module sarseq_tickgen (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Sequencer side
	sarseq_tick_if.gen tk
);
	import sarseq_pkg::*;

	logic [6:0] cnt_reg;
	logic [6:0] cnt_next;
	logic [6:0] limit;

	always_comb begin
		limit = 7'((7'h01 << tk.div_exp) - 7'h01);
		cnt_next = 7'h00;
		if (tk.run && !tk.use_rc && cnt_reg != limit) begin
			cnt_next = 7'(cnt_reg + 7'h01);
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= 7'h00;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign tk.tick = tk.run && (tk.use_rc ? tk.rc_edge : (cnt_reg == limit));
endmodule : sarseq_tickgen

// ==== dv/sarseq_analog_model.sv ====
// Comparator stand-in for the analog sample-hold core
`timescale 1ns/1ps
module sarseq_analog_model (
	// Clock
	input wire logic ref_clk,
	// Sequencer side
	input wire logic analog_power,
	input wire logic sample_en,
	input wire logic [7:0] dac_code,
	input wire logic [7:0] vin,
	output logic cmp_result
);
	logic junk_reg = 1'b0;
	always_ff @(posedge ref_clk) begin
		junk_reg <= ~junk_reg;
	end
	// No valid decision while unpowered or tracking
	assign cmp_result = (analog_power && !sample_en) ? (vin >= dac_code) : junk_reg;
endmodule : sarseq_analog_model

// ==== dv/sarseq_top_asserts.sv ====
// Port-level checker for the converter sequencer
`timescale 1ns/1ps
module sarseq_top_asserts (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// System and analog side
	input wire logic sleep_active,
	input wire logic special_event,
	input wire logic irq_req,
	input wire logic wake_req,
	input wire logic timer_clear,
	input wire logic [3:0] input_channel_select,
	input wire logic fixed_reference_channel
);
	import sarseq_pkg::*;
	logic wr_acc, wr_d1_reg, wr_d2_reg;
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	assign wr_acc = psel && penable && pwrite;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wr_d1_reg <= 1'b0;
			wr_d2_reg <= 1'b0;
		end else begin
			wr_d1_reg <= wr_acc;
			wr_d2_reg <= wr_d1_reg;
		end
	end
	////////////////////////////////////////////////////////////////
	a_clear_after_event: assert property (special_event |=> timer_clear)
		else $error("Timer clear missing after event");
	a_clear_has_cause: assert property (timer_clear |-> $past(special_event))
		else $error("Timer clear without event");
	a_wake_needs_irq: assert property (wake_req |-> irq_req)
		else $error("Wake without interrupt request");
	a_wake_in_sleep: assert property ($rose(wake_req) |-> $past(sleep_active))
		else $error("Wake raised outside sleep");
	a_irq_drop_cause: assert property ($fell(irq_req) |-> wr_d1_reg || wr_d2_reg)
		else $error("Interrupt request dropped without a write");
	a_pready_single: assert property (pready |=> !pready)
		else $error("Ready longer than one cycle");
	a_setup_answer: assert property (psel && !penable |=> pready)
		else $error("No ready after setup");
	a_read_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("Upper read bits not zero");
	a_fixed_ref_code: assert property (fixed_reference_channel == (input_channel_select == CHAN_FIXED_REF))
		else $error("Fixed reference select wrong");
	c_event: cover property (special_event ##1 timer_clear);
	c_wake: cover property ($rose(wake_req));
	c_error: cover property (pready && pslverr);
	c_irq_clear: cover property ($fell(irq_req));
endmodule : sarseq_top_asserts

bind sarseq_top sarseq_top_asserts u_chk (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_active(sleep_active),
	.special_event(special_event), .irq_req(irq_req), .wake_req(wake_req), .timer_clear(timer_clear),
	.input_channel_select(input_channel_select), .fixed_reference_channel(fixed_reference_channel));

// ==== dv/tb_sarseq_top.sv ====
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_sarseq_top;
	import sarseq_pkg::*;
	logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic sleep_active = 0, special_event = 0, rc_osc_clk = 0, cmp_result;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, irq_req, wake_req, timer_clear, analog_power, sample_en, fref, rerr;
	logic [7:0] dac_code, d, vin = 8'h00;
	logic [3:0] chan_sel;
	logic [1:0] pref;
	logic [11:0] offs [5] = '{OFS_CTRL_ZERO, OFS_CTRL_ONE, OFS_RESULT, OFS_PERIPH_FLAG, OFS_PERIPH_IRQEN};
	logic [2:0] divs [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
	int failures = 0, n_tests = 0, cyc = 0;
	int exp_q[$];
	sarseq_top dut (.ref_clk(ref_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_active(sleep_active), .special_event(special_event), .rc_osc_clk(rc_osc_clk),
		.irq_req(irq_req), .wake_req(wake_req), .timer_clear(timer_clear), .cmp_result(cmp_result),
		.analog_power(analog_power), .sample_en(sample_en), .dac_code(dac_code),
		.input_channel_select(chan_sel), .fixed_reference_channel(fref), .positive_ref_select(pref));
	sarseq_analog_model u_core (.ref_clk(ref_clk), .analog_power(analog_power), .sample_en(sample_en),
		.dac_code(dac_code), .vin(vin), .cmp_result(cmp_result));
	initial forever #5 ref_clk = ~ref_clk;
	initial forever #83 rc_osc_clk = ~rc_osc_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			failures++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] v);
		@(posedge ref_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h000000, v};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		apb(a, 1'b1, v);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		apb(a, 1'b0, 8'h00);
	endtask : rd
	// Expected result after k resolved bits, rest copies the last one
	function automatic int partial(int v, int k);
		int m;
		m = (256 >> k) - 1;
		return (v & ~m & 255) | (((v >> (8 - k)) & 1) ? m : 0);
	endfunction : partial
	task automatic start(input logic [2:0] cs, input logic [7:0] v, input int k);
		vin <= v;
		exp_q.push_back(partial(int'(v), k));
		wr(OFS_CTRL_ONE, {1'b0, cs, 4'h0});
		wr(OFS_CTRL_ZERO, 8'h01);
		wr(OFS_CTRL_ZERO, 8'h03);
	endtask : start
	task automatic wait_idle();
		rdat = 32'h2;
		for (int i = 0; i < 500 && rdat[1] !== 1'b0; i++) rd(OFS_CTRL_ZERO);
		chk(rdat & 32'h2, 32'h0);
	endtask : wait_idle
	task automatic chk_res();
		rd(OFS_RESULT);
		chk(rdat, 32'(exp_q.pop_front()));
	endtask : chk_res
	task automatic chk_reset();
		foreach (offs[i]) begin
			rd(offs[i]);
			chk(rdat, 32'h0);
		end
	endtask : chk_reset
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h8F4AA15A));
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		chk_reset();
		rd(12'h014);
		chk(32'(rerr), 32'h1);
		repeat (4) begin
			d = 8'($urandom);
			wr(OFS_CTRL_ONE, d);
			rd(OFS_CTRL_ONE);
			chk(rdat, 32'(d & CTRL_ONE_MASK));
			chk(32'(pref), 32'(d[1:0]));
		end
		for (int c = 0; c < 16; c++) begin
			wr(OFS_CTRL_ZERO, {2'b11, 4'(c), 2'b00});
			rd(OFS_CTRL_ZERO);
			chk(rdat, 32'(c * 4));
			chk(32'(chan_sel), 32'(c));
			chk(32'(fref), 32'(c == 15));
		end
		wr(OFS_CTRL_ZERO, 8'h02);
		rd(OFS_CTRL_ZERO);
		chk(rdat, 32'h0);
		chk(32'(analog_power), 32'h0);
		for (int i = 0; i < 7; i++) begin
			wr(OFS_PERIPH_IRQEN, i < 6 ? 8'h40 : 8'h00);
			start(i < 6 ? divs[i] : 3'h0, 8'($urandom), 8);
			rd(OFS_CTRL_ZERO);
			chk(rdat, 32'h3);
			wait_idle();
			chk_res();
			rd(OFS_PERIPH_FLAG);
			chk(rdat & 32'h40, 32'h40);
			chk(32'(irq_req), i < 6 ? 32'h1 : 32'h0);
			wr(OFS_PERIPH_FLAG, 8'h40);
			rd(OFS_PERIPH_FLAG);
			chk(rdat & 32'h40, 32'h40);
			wr(OFS_PERIPH_FLAG, 8'h00);
			rd(OFS_PERIPH_FLAG);
			chk(rdat & 32'h40, 32'h0);
		end
		start(3'h6, 8'hBF, 4);
		repeat (300) @(posedge ref_clk);
		// Bits 7..5 of 0xBF resolved, bit 4 on trial, core holding
		chk(32'(dac_code), 32'hB0);
		chk(32'(sample_en), 32'h0);
		repeat (20) @(posedge ref_clk);
		wr(OFS_CTRL_ZERO, 8'h01);
		chk_res();
		start(3'h6, 8'($urandom), 8);
		void'(exp_q.pop_back());
		sleep_active <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk(32'(analog_power), 32'h0);
		rd(OFS_CTRL_ZERO);
		chk(rdat, 32'h1);
		sleep_active <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			wr(OFS_PERIPH_IRQEN, i ? 8'h40 : 8'h00);
			start(i ? 3'h7 : 3'h3, 8'($urandom), 8);
			sleep_active <= 1'b1;
			wait_idle();
			repeat (2) @(posedge ref_clk);
			chk(32'(wake_req), 32'(i));
			chk(32'(analog_power), 32'(i));
			rd(OFS_CTRL_ZERO);
			chk(rdat, 32'h1);
			chk_res();
			sleep_active <= 1'b0;
			wr(OFS_PERIPH_FLAG, 8'h00);
		end
		wr(OFS_CTRL_ONE, 8'h00);
		d = 8'($urandom);
		vin <= d;
		exp_q.push_back(int'(d));
		special_event <= 1'b1;
		@(posedge ref_clk);
		special_event <= 1'b0;
		@(posedge ref_clk);
		chk(32'(timer_clear), 32'h1);
		rd(OFS_CTRL_ZERO);
		chk(rdat & 32'h2, 32'h2);
		wait_idle();
		chk_res();
		start(3'h6, 8'h55, 8);
		repeat (40) @(posedge ref_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		chk(32'(analog_power), 32'h0);
		chk_reset();
		print_verdict();
	end
endmodule : tb_sarseq_top
